// *** rtl/fus_pkg.sv ***
// constants shared by the fifo uart status-flag block
// assumes one 25 MHz clock and an AXI4-Lite master with 32-bit data
package fus_pkg;
    // register byte addresses on the AXI4-Lite port
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_FIFO_CTRL = 8'h04;
    localparam logic [7:0] ADDR_SER_CTRL = 8'h08;
    localparam logic [7:0] ADDR_TX_DATA = 8'h0c;
    localparam logic [7:0] ADDR_RX_DATA = 8'h10;
    localparam logic [7:0] ADDR_FIFO_COUNT = 8'h14;

    // serial_status lower-byte flag positions
    localparam int BIT_RX_FAULT = 7;
    localparam int BIT_TX_DONE = 6;
    localparam int BIT_TX_LOW = 5;
    localparam int BIT_BREAK = 4;
    localparam int BIT_STOP_FAULT = 3;
    localparam int BIT_PAR_FAULT = 2;
    localparam int BIT_RX_FULL = 1;
    localparam int BIT_RX_IDLE = 0;

    // reset values and the mask of write-0-to-clear flags
    localparam logic [15:0] STATUS_RST = 16'h0060;
    localparam logic [7:0] CLEARABLE = 8'hf3;
    localparam logic [7:0] FIFO_CTRL_RST = 8'h00;
    localparam logic [7:0] SER_CTRL_RST = 8'h00;

    // serial_control and fifo_control field positions
    localparam int SCTRL_TX_ENABLE = 5;
    localparam int SCTRL_RX_ENABLE = 4;
    localparam int FCTRL_TX_SEL_LO = 4;
    localparam int FCTRL_RX_SEL_LO = 6;

    // trigger thresholds by selection code 0..3
    localparam logic [4:0] TX_TRIG0 = 5'h08;
    localparam logic [4:0] TX_TRIG1 = 5'h04;
    localparam logic [4:0] TX_TRIG2 = 5'h02;
    localparam logic [4:0] TX_TRIG3 = 5'h01;
    localparam logic [4:0] RX_TRIG0 = 5'h01;
    localparam logic [4:0] RX_TRIG1 = 5'h04;
    localparam logic [4:0] RX_TRIG2 = 5'h08;
    localparam logic [4:0] RX_TRIG3 = 5'h0e;

    // fifo depth in entries
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    // idle time after the last stop bit, in etu
    localparam logic [3:0] IDLE_ETU = 4'hf;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/fus_status_flags.sv ***
// status-flag logic of a fifo uart: serial_status, both fifos, thresholds
// assumes the shifters and baud generator sit beside it on mclk; only
// the raw receive line arrives asynchronously
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

// What this block does
// RL1: 16-bit status: error count high, flags low
// RL2: writing 1 ignored; 0 clears after read-1
// RL3: stop and parity fault bits read-only
// RL4: status loads 0060 at reset and standby
// RL5: flag positions fixed from bit 7 down
// RL6: zero first stop bit sets receive fault
// RL7: parity mismatch sets receive fault
// RL8: receiver disable leaves receive fault alone
// RL9: faulty characters still enter receive fifo
// RL10: only first stop bit is checked
// RL11: writing transmit data clears transmit done
// RL12: reset, standby, transmitter disable set done
// RL13: done when last bit out, fifo empty
// RL14: low flag sets when pop drops below trigger
// RL15: low flag clears above trigger or read-write
// RL16: low flag forced to 1 by reset/standby
// RL17: 16-byte transmit fifo, writes when full dropped
// RL18: transmit count readable in upper count byte
// RL19: break on line sets break flag
// RL20: stop fault follows character being read
// RL21: parity fault follows character being read
// RL22: full flag tracks receive trigger threshold
// RL23: idle flag after 15 etu below trigger
// RL24: thresholds come from fifo_control selection fields
module fus_status_flags (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // power states
    input wire logic standby,
    input wire logic moduleStandby,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // receive shifter side
    input wire logic rxLinePin,
    input wire logic etuTick,
    input wire logic rxCharDone,
    input wire logic [7:0] rxData,
    input wire logic rxParityBit,
    input wire logic rxFirstStop,
    input wire logic parityEnable,
    input wire logic parityOdd,
    // transmit shifter side
    input wire logic txShiftLoad,
    input wire logic txLastBitOut,
    output logic [7:0] txHeadData,
    output logic txDataValid,
    // control and status views
    output logic txEnable,
    output logic rxEnable,
    output logic [15:0] statusView
);
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] armed;
        logic [7:0] errCount;
        logic [7:0] fctrl;
        logic [7:0] sctrl;
        logic [15:0][7:0] txMem;
        logic [3:0] txRd;
        logic [3:0] txWr;
        logic [4:0] txCnt;
        logic [15:0][9:0] rxMem;
        logic [3:0] rxRd;
        logic [3:0] rxWr;
        logic [4:0] rxCnt;
        logic breakHold;
        logic idleRun;
        logic [3:0] idleCnt;
        logic lineMeta;
        logic lineSafe;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } fus_state_s;

    fus_state_s s_reg;
    fus_state_s s_next;

    logic doWr;
    logic doRd;
    logic stWr;
    logic txPush;
    logic txPop;
    logic rxPush;
    logic rxPop;
    logic frameErr;
    logic parErr;
    logic [9:0] rxHead;
    logic [4:0] txCntNew;
    logic [4:0] rxCntNew;
    logic [4:0] txTrig;
    logic [4:0] rxTrig;
    logic [31:0] rdWord;
    logic [1:0] rdResp;
    logic [1:0] wrResp;

    // AXI handshakes: a held address or data blocks until the response leaves
    assign awready = !s_reg.awHeld && !s_reg.bValid;
    assign wready = !s_reg.wHeld && !s_reg.bValid;
    assign arready = !s_reg.rValid;
    assign bvalid = s_reg.bValid;
    assign bresp = s_reg.bResp;
    assign rvalid = s_reg.rValid;
    assign rdata = s_reg.rData;
    assign rresp = s_reg.rResp;

    // head is a plain mux of the array; the shifter takes it on its load edge
    assign txHeadData = s_reg.txMem[s_reg.txRd];
    assign txDataValid = s_reg.txCnt != 5'h00;
    assign txEnable = s_reg.sctrl[fus_pkg::SCTRL_TX_ENABLE];
    assign rxEnable = s_reg.sctrl[fus_pkg::SCTRL_RX_ENABLE];
    assign statusView = {s_reg.errCount, s_reg.flags}; // RL1

    // thresholds from fifo_control
    always_comb begin
        unique case (s_reg.fctrl[fus_pkg::FCTRL_TX_SEL_LO +: 2]) // RL24
            2'h0: txTrig = fus_pkg::TX_TRIG0;
            2'h1: txTrig = fus_pkg::TX_TRIG1;
            2'h2: txTrig = fus_pkg::TX_TRIG2;
            2'h3: txTrig = fus_pkg::TX_TRIG3;
        endcase
        unique case (s_reg.fctrl[fus_pkg::FCTRL_RX_SEL_LO +: 2]) // RL24
            2'h0: rxTrig = fus_pkg::RX_TRIG0;
            2'h1: rxTrig = fus_pkg::RX_TRIG1;
            2'h2: rxTrig = fus_pkg::RX_TRIG2;
            2'h3: rxTrig = fus_pkg::RX_TRIG3;
        endcase
    end

    // read mux; unmapped addresses answer SLVERR with zero data
    always_comb begin
        rdWord = 32'h0000_0000;
        rdResp = fus_pkg::RESP_OKAY;
        case (araddr)
            fus_pkg::ADDR_STATUS: rdWord = {16'h0000, s_reg.errCount, s_reg.flags};
            fus_pkg::ADDR_FIFO_CTRL: rdWord = {24'h00_0000, s_reg.fctrl};
            fus_pkg::ADDR_SER_CTRL: rdWord = {24'h00_0000, s_reg.sctrl};
            fus_pkg::ADDR_TX_DATA: rdWord = 32'h0000_0000;
            fus_pkg::ADDR_RX_DATA: rdWord = {24'h00_0000, rxHead[7:0]};
            fus_pkg::ADDR_FIFO_COUNT:
                rdWord = {16'h0000, 3'h0, s_reg.txCnt, 3'h0, s_reg.rxCnt}; // RL18
            default: rdResp = fus_pkg::RESP_SLVERR;
        endcase
    end

    always_comb begin
        case (s_reg.awAddr)
            fus_pkg::ADDR_STATUS, fus_pkg::ADDR_FIFO_CTRL, fus_pkg::ADDR_SER_CTRL,
            fus_pkg::ADDR_TX_DATA, fus_pkg::ADDR_RX_DATA, fus_pkg::ADDR_FIFO_COUNT:
                wrResp = fus_pkg::RESP_OKAY;
            default: wrResp = fus_pkg::RESP_SLVERR;
        endcase
    end

    // event decode
    assign doWr = s_reg.awHeld && s_reg.wHeld && !s_reg.bValid;
    // arready is the only gate, so the read address is used live, not latched
    assign doRd = arvalid && !s_reg.rValid;
    // byte lane 0 only: the error count in the upper byte is never writable
    assign stWr = doWr && s_reg.awAddr == fus_pkg::ADDR_STATUS && s_reg.wStrb[0];
    // a full fifo silently drops the written byte
    assign txPush = doWr && s_reg.awAddr == fus_pkg::ADDR_TX_DATA && s_reg.wStrb[0]
        && s_reg.txCnt != fus_pkg::FIFO_DEPTH; // RL17
    assign txPop = txShiftLoad && s_reg.txCnt != 5'h00;
    assign frameErr = !rxFirstStop; // RL6 RL10
    assign parErr = parityEnable && ((^{rxData, rxParityBit}) != parityOdd); // RL7
    // frames after a break are held back until the line returns to mark
    assign rxPush = rxCharDone && rxEnable && !s_reg.breakHold
        && s_reg.rxCnt != fus_pkg::FIFO_DEPTH; // RL9
    assign rxHead = s_reg.rxMem[s_reg.rxRd];
    // reading an empty fifo returns the stale head and pops nothing
    assign rxPop = doRd && araddr == fus_pkg::ADDR_RX_DATA && s_reg.rxCnt != 5'h00;
    assign txCntNew = s_reg.txCnt + {4'h0, txPush} - {4'h0, txPop};
    assign rxCntNew = s_reg.rxCnt + {4'h0, rxPush} - {4'h0, rxPop};

    always_comb begin
        s_next = s_reg;
        // receive line synchroniser
        s_next.lineMeta = rxLinePin;
        s_next.lineSafe = s_reg.lineMeta;

        // AXI write channels, taken in either order
        if (awvalid && awready) begin
            s_next.awHeld = 1'b1;
            s_next.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            s_next.wHeld = 1'b1;
            s_next.wData = wdata;
            s_next.wStrb = wstrb;
        end
        if (doWr) begin
            s_next.awHeld = 1'b0;
            s_next.wHeld = 1'b0;
            s_next.bValid = 1'b1;
            s_next.bResp = wrResp;
        end
        if (s_reg.bValid && bready) begin
            s_next.bValid = 1'b0;
        end
        if (s_reg.rValid && rready) begin
            s_next.rValid = 1'b0;
        end
        if (doRd) begin
            s_next.rValid = 1'b1;
            s_next.rData = rdWord;
            s_next.rResp = rdResp;
        end

        // control register writes
        if (doWr && s_reg.wStrb[0] && s_reg.awAddr == fus_pkg::ADDR_FIFO_CTRL) begin
            s_next.fctrl = s_reg.wData[7:0];
        end
        if (doWr && s_reg.wStrb[0] && s_reg.awAddr == fus_pkg::ADDR_SER_CTRL) begin
            s_next.sctrl = s_reg.wData[7:0];
        end

        // software clear: only a 0 onto a flag seen as 1 counts, 1s do nothing
        if (stWr) begin
            s_next.flags = s_reg.flags & ~(fus_pkg::CLEARABLE & s_reg.armed
                & ~s_reg.wData[7:0]); // RL2 RL3
            s_next.armed = 8'h00;
        end
        if (doRd && araddr == fus_pkg::ADDR_STATUS) begin
            s_next.armed = s_next.armed | (s_reg.flags & fus_pkg::CLEARABLE); // RL2
        end

        // transmit fifo
        if (txPush) begin
            s_next.txMem[s_reg.txWr] = s_reg.wData[7:0];
            s_next.txWr = s_reg.txWr + 4'h1;
        end
        if (txPop) begin
            s_next.txRd = s_reg.txRd + 4'h1;
        end
        s_next.txCnt = txCntNew;

        // receive fifo holds {stop fault, parity fault, data}
        if (rxPush) begin
            s_next.rxMem[s_reg.rxWr] = {frameErr, parErr, rxData}; // RL9
            s_next.rxWr = s_reg.rxWr + 4'h1;
        end
        if (rxPop) begin
            s_next.rxRd = s_reg.rxRd + 4'h1;
        end
        s_next.rxCnt = rxCntNew;
        s_next.errCount = s_reg.errCount + {7'h00, rxPush && (frameErr || parErr)}
            - {7'h00, rxPop && (rxHead[9] || rxHead[8])}; // RL1

        // hardware clears come first, sets last so a set wins over any clear
        if (txPush) begin
            s_next.flags[fus_pkg::BIT_TX_DONE] = 1'b0; // RL11
        end
        if (txPush && txCntNew > txTrig) begin
            s_next.flags[fus_pkg::BIT_TX_LOW] = 1'b0; // RL15
        end
        if (rxPop && rxCntNew < rxTrig) begin
            s_next.flags[fus_pkg::BIT_RX_FULL] = 1'b0; // RL22
        end
        if (rxPop) begin
            s_next.flags[fus_pkg::BIT_STOP_FAULT] = rxHead[9]; // RL20
            s_next.flags[fus_pkg::BIT_PAR_FAULT] = rxHead[8]; // RL21
        end
        // only the 1-to-0 step of the enable sets done; it is not held while off
        if (txEnable && !s_next.sctrl[fus_pkg::SCTRL_TX_ENABLE]) begin
            s_next.flags[fus_pkg::BIT_TX_DONE] = 1'b1; // RL12
        end
        if (txLastBitOut && txCntNew == 5'h00) begin
            s_next.flags[fus_pkg::BIT_TX_DONE] = 1'b1; // RL13
        end
        if (txPop && txCntNew < txTrig) begin
            s_next.flags[fus_pkg::BIT_TX_LOW] = 1'b1; // RL14
        end
        // receiver disable has no path into the fault flag
        // a full fifo drops the character but the fault still registers
        if (rxCharDone && rxEnable && (frameErr || parErr)) begin
            s_next.flags[fus_pkg::BIT_RX_FAULT] = 1'b1; // RL6 RL7 RL8
        end
        if (rxPush && rxCntNew > rxTrig) begin
            s_next.flags[fus_pkg::BIT_RX_FULL] = 1'b1; // RL22
        end

        // break: all-space frame with framing fault while the line is low
        if (rxCharDone && rxEnable && frameErr && rxData == 8'h00 && !s_reg.lineSafe) begin
            s_next.flags[fus_pkg::BIT_BREAK] = 1'b1; // RL19
            s_next.breakHold = 1'b1;
        end else if (s_reg.lineSafe) begin
            s_next.breakHold = 1'b0;
        end

        // idle timer counts etu from the last stop bit
        if (rxCharDone && rxEnable) begin
            s_next.idleRun = 1'b1;
            s_next.idleCnt = 4'h0;
        end else if (s_reg.idleRun && etuTick) begin
            s_next.idleCnt = s_reg.idleCnt + 4'h1;
            if (s_reg.idleCnt + 4'h1 == fus_pkg::IDLE_ETU) begin
                s_next.idleRun = 1'b0;
                // at the trigger neither flag sets; above it is the full flag's business
                if (rxCntNew != 5'h00 && rxCntNew < rxTrig) begin
                    s_next.flags[fus_pkg::BIT_RX_IDLE] = 1'b1; // RL23
                end
            end
        end

        // a flag that is 0 after this edge loses its arming, so a later
        // hardware set is not wiped by a clear aimed at the old event
        s_next.armed = s_next.armed & s_next.flags; // RL2

        // standby reinitialises the serial side but keeps the bus alive
        // fifo_control survives so thresholds need not be rewritten after wake-up
        if (standby || moduleStandby) begin
            s_next.flags = fus_pkg::STATUS_RST[7:0]; // RL4 RL12 RL16
            s_next.errCount = fus_pkg::STATUS_RST[15:8];
            s_next.armed = 8'h00;
            s_next.sctrl = fus_pkg::SER_CTRL_RST;
            s_next.txRd = 4'h0;
            s_next.txWr = 4'h0;
            s_next.txCnt = 5'h00;
            s_next.rxRd = 4'h0;
            s_next.rxWr = 4'h0;
            s_next.rxCnt = 5'h00;
            s_next.breakHold = 1'b0;
            s_next.idleRun = 1'b0;
        end

        // synchronous reset: constants only
        if (rst) begin
            s_next = '0;
            s_next.flags = fus_pkg::STATUS_RST[7:0]; // RL4 RL5 RL16
            s_next.errCount = fus_pkg::STATUS_RST[15:8];
            s_next.fctrl = fus_pkg::FIFO_CTRL_RST;
            s_next.sctrl = fus_pkg::SER_CTRL_RST;
            s_next.lineMeta = 1'b1;
            s_next.lineSafe = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        s_reg <= s_next;
    end
endmodule

// *** verification/fus_status_flags_monitor.sv ***
// concurrent checks on the status-flag block
// assumes binding to fus_status_flags, seeing only its ports
`timescale 1ns/100ps
module fus_status_flags_monitor (
    // clock, reset, power
    input wire logic mclk,
    input wire logic rst,
    input wire logic standby,
    input wire logic moduleStandby,
    // bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [7:0] awaddr,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [7:0] araddr,
    // shifter side
    input wire logic rxCharDone,
    input wire logic [7:0] rxData,
    input wire logic rxParityBit,
    input wire logic rxFirstStop,
    input wire logic parityEnable,
    input wire logic parityOdd,
    input wire logic txLastBitOut,
    input wire logic txDataValid,
    // views
    input wire logic txEnable,
    input wire logic rxEnable,
    input wire logic [15:0] statusView
);
    // address of the last accepted write, since awaddr is gone by the response
    logic [7:0] lastAw_reg;
    always_ff @(posedge mclk) begin
        if (rst) lastAw_reg <= 8'h00;
        else if (awvalid && awready) lastAw_reg <= awaddr;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence txWrite;
        $rose(bvalid) && lastAw_reg == fus_pkg::ADDR_TX_DATA && bresp == fus_pkg::RESP_OKAY;
    endsequence
    sequence rxPop;
        arvalid && arready && araddr == fus_pkg::ADDR_RX_DATA;
    endsequence
    power_reinit_a: assert property ((standby || moduleStandby)
        |=> statusView == fus_pkg::STATUS_RST) else $error("status not reinitialised by standby");
    ro_faults_a: assert property ($changed(statusView[3:2])
        && !$past(standby || moduleStandby)
        |-> $past(arvalid && arready && araddr == fus_pkg::ADDR_RX_DATA))
        else $error("fault bits moved");
    tx_write_a: assert property (txWrite |-> !statusView[6])
        else $error("tx done not cleared by data write");
    tx_disable_a: assert property ($fell(txEnable) |-> ##[0:1] statusView[6])
        else $error("tx done not set by disable");
    tx_end_a: assert property (txLastBitOut && !txDataValid |=> statusView[6])
        else $error("tx done not set at end");
    stop_fault_a: assert property (rxCharDone && rxEnable && !rxFirstStop
        && !(standby || moduleStandby) |=> statusView[7])
        else $error("stop fault missed");
    parity_fault_a: assert property (rxCharDone && rxEnable && parityEnable
        && !(standby || moduleStandby) && ((^{rxData, rxParityBit}) != parityOdd)
        |=> statusView[7]) else $error("parity missed");
    rx_disable_a: assert property ($fell(rxEnable) && !rxCharDone
        && !(standby || moduleStandby) |=> $stable(statusView[7])) else $error("fault changed");
    pop_seen_c: cover property (rxPop);
endmodule
bind fus_status_flags fus_status_flags_monitor mon_u (.mclk, .rst, .standby, .moduleStandby,
    .awvalid, .awready, .awaddr, .bvalid, .bresp, .arvalid, .arready, .araddr, .rxCharDone,
    .rxData, .rxParityBit, .rxFirstStop, .parityEnable, .parityOdd, .txLastBitOut,
    .txDataValid, .txEnable, .rxEnable, .statusView);

// *** verification/fus_line_model.sv ***
// line-side partner: receive shifter results and transmit shifter pulses
// assumes the bench calls one task at a time
`timescale 1ns/100ps
module fus_line_model (
    // clock
    input wire logic mclk,
    // receive side
    output logic rxLinePin = 1'h1,
    output logic etuTick = 1'h0,
    output logic rxCharDone = 1'h0,
    output logic [7:0] rxData = 8'h00,
    output logic rxParityBit = 1'h0,
    output logic rxFirstStop = 1'h1,
    // transmit side
    output logic txShiftLoad = 1'h0,
    output logic txLastBitOut = 1'h0,
    input wire logic [7:0] txHeadData,
    input wire logic txDataValid
);
    logic [7:0] txGot = 8'h00;
    task automatic rxChar(input logic [7:0] d, input logic p, input logic s, input logic line_break_flag);
        if (line_break_flag) begin
            @(posedge mclk);
            rxLinePin <= 1'h0;
            repeat (4) @(posedge mclk);
        end
        @(posedge mclk);
        rxData <= d;
        rxParityBit <= p;
        rxFirstStop <= s;
        rxCharDone <= 1'h1;
        @(posedge mclk);
        rxCharDone <= 1'h0;
        // released lines show the inverse so a stale value never looks valid
        rxData <= ~d;
        rxParityBit <= ~p;
        rxFirstStop <= ~s;
        @(posedge mclk);
    endtask
    task automatic lineIdle;
        @(posedge mclk);
        rxLinePin <= 1'h1;
        repeat (4) @(posedge mclk);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge mclk);
            etuTick <= 1'h1;
            @(posedge mclk);
            etuTick <= 1'h0;
        end
    endtask
    task automatic txChar;
        @(negedge mclk);
        txGot = txHeadData;
        @(posedge mclk);
        txShiftLoad <= 1'h1;
        @(posedge mclk);
        txShiftLoad <= 1'h0;
        repeat (3) @(posedge mclk);
        txLastBitOut <= 1'h1;
        @(posedge mclk);
        txLastBitOut <= 1'h0;
        @(posedge mclk);
    endtask
endmodule

// *** verification/fus_status_flags_tb.sv ***
// self-checking bench for the status-flag block over AXI4-Lite
// assumes fus_line_model on the shifter side and the bound monitor
`timescale 1ns/100ps
module fus_status_flags_tb;
    localparam logic [7:0] ST = fus_pkg::ADDR_STATUS;
    localparam logic [7:0] SC = fus_pkg::ADDR_SER_CTRL;
    localparam logic [7:0] TX = fus_pkg::ADDR_TX_DATA;
    localparam logic [7:0] CNT = fus_pkg::ADDR_FIFO_COUNT;
    logic mclk = 1'h0, rst = 1'h1, standby = 1'h0, moduleStandby = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, txDataValid, txEnable, rxEnable;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, rxData, txHeadData;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    logic rxLinePin, etuTick, rxCharDone, rxParityBit, rxFirstStop, txShiftLoad, txLastBitOut;
    logic parityEnable = 1'h0, parityOdd = 1'h0;
    logic [15:0] statusView;
    logic [7:0] rxq [3] = '{8'h03, 8'h01, 8'h07};
    logic [15:0] stq [3] = '{16'h03d3, 16'h02d5, 16'h01d9};
    int fails = 0, n_tests = 0;
    always #20 mclk = ~mclk;
    fus_status_flags dut_u (.mclk, .rst, .standby, .moduleStandby, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .rvalid, .rready, .rdata, .rresp, .rxLinePin, .etuTick, .rxCharDone, .rxData,
        .rxParityBit, .rxFirstStop, .parityEnable, .parityOdd, .txShiftLoad, .txLastBitOut,
        .txHeadData, .txDataValid, .txEnable, .rxEnable, .statusView);
    fus_line_model lm_u (.mclk, .rxLinePin, .etuTick, .rxCharDone, .rxData, .rxParityBit,
        .rxFirstStop, .txShiftLoad, .txLastBitOut, .txHeadData, .txDataValid);
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        logic ta, tw, tb;
        logic [1:0] rs;
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= {24'h0, d};
        bready <= 1'h1;
        do begin
            @(negedge mclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rs = bresp;
            n++;
            @(posedge mclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end while (!tb && n < 40);
        bready <= 1'h0;
        if (!tb) begin
            fails++;
            end_of_test();
        end
        chk($sformatf("bresp %h", a), {32'h0, rs}, 34'h0);
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n = 0;
        logic ta, tr;
        logic [33:0] got;
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do begin
            @(negedge mclk);
            ta = arvalid && arready;
            tr = rvalid;
            got = {rresp, rdata};
            n++;
            @(posedge mclk);
            if (ta) arvalid <= 1'h0;
        end while (!tr && n < 40);
        rready <= 1'h0;
        if (!tr) begin
            fails++;
            end_of_test();
        end
        chk($sformatf("reg %h", a), got, {er, e});
        @(posedge mclk);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        rd(ST, 32'h0060, 2'h0);
        rd(8'h18, 32'h0, 2'h2);
        wr(SC, 8'h30);
        chk("enables", {32'h0, txEnable, rxEnable}, 34'h3);
        rd(SC, 32'h0030, 2'h0);
        for (int i = 0; i < 17; i++) begin
            wr(TX, 8'h11 + i[7:0]);
            if (i == 7) rd(ST, 32'h0020, 2'h0);
        end
        rd(ST, 32'h0000, 2'h0);
        rd(CNT, 32'h1000, 2'h0);
        for (int i = 0; i < 16; i++) begin
            lm_u.txChar();
            chk("txHead", {26'h0, lm_u.txGot}, {26'h0, 8'h11 + i[7:0]});
            if (i == 7) rd(ST, 32'h0000, 2'h0);
            if (i == 8) rd(ST, 32'h0020, 2'h0);
        end
        rd(ST, 32'h0060, 2'h0);
        wr(ST, 8'hff);
        wr(ST, 8'h00);
        rd(ST, 32'h0060, 2'h0);
        wr(ST, 8'h00);
        rd(ST, 32'h0000, 2'h0);
        wr(SC, 8'h10);
        rd(ST, 32'h0040, 2'h0);
        wr(fus_pkg::ADDR_FIFO_CTRL, 8'h40);
        rd(fus_pkg::ADDR_FIFO_CTRL, 32'h0040, 2'h0);
        parityEnable <= 1'h1;
        lm_u.rxChar(8'h03, 1'h0, 1'h1, 1'h0);
        lm_u.ticks(14);
        rd(ST, 32'h0040, 2'h0);
        lm_u.ticks(1);
        rd(ST, 32'h0041, 2'h0);
        lm_u.rxChar(8'h01, 1'h0, 1'h1, 1'h0);
        lm_u.rxChar(8'h07, 1'h1, 1'h0, 1'h0);
        lm_u.rxChar(8'h00, 1'h0, 1'h0, 1'h1);
        rd(ST, 32'h03d1, 2'h0);
        rd(CNT, 32'h0004, 2'h0);
        lm_u.lineIdle();
        lm_u.rxChar(8'h55, 1'h0, 1'h1, 1'h0);
        wr(SC, 8'h00);
        rd(ST, 32'h03d3, 2'h0);
        for (int i = 0; i < 3; i++) begin
            rd(fus_pkg::ADDR_RX_DATA, {24'h0, rxq[i]}, 2'h0);
            rd(ST, {16'h0, stq[i]}, 2'h0);
        end
        wr(ST, 8'h00);
        rd(ST, 32'h0108, 2'h0);
        standby <= 1'h1;
        repeat (2) @(posedge mclk);
        standby <= 1'h0;
        rd(ST, 32'h0060, 2'h0);
        rd(CNT, 32'h0000, 2'h0);
        wr(TX, 8'h99);
        rd(ST, 32'h0020, 2'h0);
        rd(CNT, 32'h0100, 2'h0);
        moduleStandby <= 1'h1;
        repeat (2) @(posedge mclk);
        moduleStandby <= 1'h0;
        rd(ST, 32'h0060, 2'h0);
        rd(CNT, 32'h0000, 2'h0);
        chk("statusView", {18'h0, statusView}, 34'h0060);
        end_of_test();
    end
endmodule
